// ==== design/vrs_pkg.sv ====
// constants shared by the regulator i2c register slave
// Function
// - voltage code bits 6..0 hold the code, reset value 0110010
// - host-control bit 1 lets stored code set output; resets to 0
// - writing 0 to host-control returns to external control at any time
// - protection-suppress bit 1 disables protection during code change; resets 0
// - light-load bit 0 selects PFM, 1 selects PWM; resets 1
// - protection-mode bit 0 auto-recovery, 1 latch-off; resets 1
// - voltage byte with bad parity gets no ack and is not stored
// - invalid control write leaves the control register unchanged
// - voltage read returns stored parity bit and seven-bit code
// - after START compare address, ack on ninth clock when it matches
// - on mismatch no ack, ignore bits until next START
// - bit after address: 0 write, 1 read
// - read shifts eight bits, then idles after STOP regardless of ack
`default_nettype none
package vrs_pkg;
  localparam logic [7:0] VRS_IDX_VOLT = 8'h00;
  localparam logic [7:0] VRS_IDX_CTRL = 8'h01;
  localparam logic [6:0] VRS_VOLT_RST = 7'h32;
  localparam logic [6:0] VRS_DEV_ADDR = 7'h34;  // arbitrary default address
  localparam int VRS_CTL_HOST = 7;
  localparam int VRS_CTL_SUPP = 4;
  localparam int VRS_CTL_PWM = 3;
  localparam int VRS_CTL_LATCH = 0;
  localparam logic [7:0] VRS_CTL_MASK = 8'h99;  // writable control bits
  localparam logic [7:0] VRS_CTL_RST = 8'h09;
  typedef enum logic [2:0] {
    VRS_IDLE = 3'b000,
    VRS_ADDR = 3'b001,
    VRS_ACK = 3'b010,
    VRS_WRX = 3'b011,
    VRS_TXB = 3'b100,
    VRS_MACK = 3'b101,
    VRS_SKIP = 3'b110
  } vrs_state_t;
endpackage
`default_nettype wire

// ==== design/vrs_sync.sv ====
// two-flop synchroniser with edge and level outputs
`default_nettype none
module vrs_sync
  import vrs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic s1_q;
  logic s2_q;
  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      meta_q <= din;
      s1_q <= meta_q;
      s2_q <= s1_q;
    end
  end
  assign dout = s1_q;
  assign rise = s1_q & ~s2_q;
  assign fall = ~s1_q & s2_q;
endmodule
`default_nettype wire

// ==== design/vrs_i2c_slave.sv ====
// i2c target holding the voltage code and regulator control registers
`default_nettype none
module vrs_i2c_slave
  import vrs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [6:0] voltCode,
  output logic voltParity,
  output logic hostControl,
  output logic protSuppress,
  output logic lightLoadPwm,
  output logic protLatchOff
);
  logic scl;
  logic sclRise;
  logic sclFall;
  logic sda;
  logic sdaRise;
  logic sdaFall;
  vrs_sync uScl (.clk(clk), .rst(rst), .din(sclIn), .dout(scl), .rise(sclRise),
    .fall(sclFall));
  vrs_sync uSda (.clk(clk), .rst(rst), .din(sdaIn), .dout(sda), .rise(sdaRise),
    .fall(sdaFall));

  ////////////////////////////////////////////////////////////////////////////
  logic startSeen;
  logic stopSeen;
  // sda moving while scl has stood high for two samples marks start or stop;
  // our own sda change may land in the same sample as an scl rise, never a frame edge
  assign startSeen = scl & ~sclRise & sdaFall;
  assign stopSeen = scl & ~sclRise & sdaRise;

  vrs_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic readMode_q;
  logic idxPhase_q;
  logic [7:0] regIdx_q;
  logic [7:0] volt_q;
  logic [7:0] ctrl_q;
  logic ackOk_q;
  logic [7:0] rxByte;
  logic parityOk;
  logic [7:0] rdData;

  assign rxByte = {shift_q[6:0], sda};
  assign parityOk = (rxByte[7] == ~(^rxByte[6:0]));
  assign rdData = (regIdx_q == VRS_IDX_CTRL) ? ctrl_q : volt_q;

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine: bits sampled on scl rise, sda changed on scl fall
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= VRS_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      readMode_q <= 1'b0;
      idxPhase_q <= 1'b0;
      ackOk_q <= 1'b0;
    end else if (startSeen) begin
      state_q <= VRS_ADDR;
      bitCnt_q <= 4'h0;
    end else if (stopSeen) begin
      state_q <= VRS_IDLE;
    end else begin
      unique case (state_q)
        VRS_IDLE, VRS_SKIP: begin
          bitCnt_q <= 4'h0;
        end
        VRS_ADDR: begin
          if (sclRise) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_q <= 4'h0;
            if (shift_q[7:1] == VRS_DEV_ADDR) begin
              readMode_q <= shift_q[0];
              idxPhase_q <= ~shift_q[0];
              ackOk_q <= 1'b1;
              state_q <= VRS_ACK;
            end else begin
              state_q <= VRS_SKIP;
            end
          end
        end
        VRS_ACK: begin
          if (sclFall) begin
            bitCnt_q <= 4'h0;
            if (!ackOk_q) begin
              state_q <= VRS_SKIP;
            end else if (readMode_q) begin
              shift_q <= rdData;
              state_q <= VRS_TXB;
            end else begin
              state_q <= VRS_WRX;
            end
          end
        end
        VRS_WRX: begin
          if (sclRise) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            // no ack when voltage parity bad
            ackOk_q <= idxPhase_q || regIdx_q != VRS_IDX_VOLT || (shift_q[7] ==
              ~(^shift_q[6:0]));
            idxPhase_q <= 1'b0;
            state_q <= VRS_ACK;
          end
        end
        VRS_TXB: begin
          if (sclFall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7) begin
              state_q <= VRS_MACK;
            end
          end
        end
        VRS_MACK: begin
          // one byte only; ack or nack, wait for stop
          if (sclFall) begin
            state_q <= VRS_SKIP;
          end
        end
        default: begin
          state_q <= VRS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic wrDone;
  // completed data byte, taken as the ninth-bit ack begins
  assign wrDone = !startSeen && !stopSeen && state_q == VRS_WRX && sclFall && bitCnt_q == 4'h8;

  always_ff @(posedge clk) begin
    if (rst) begin
      regIdx_q <= VRS_IDX_VOLT;
    end else if (wrDone && idxPhase_q) begin
      regIdx_q <= shift_q;
    end
  end

  // voltage code register, parity stored alongside
  always_ff @(posedge clk) begin
    if (rst) begin
      volt_q <= {~(^VRS_VOLT_RST), VRS_VOLT_RST};
    end else if (wrDone && !idxPhase_q && regIdx_q == VRS_IDX_VOLT &&
                 shift_q[7] == ~(^shift_q[6:0])) begin
      volt_q <= shift_q;
    end
  end

  // control written only for a valid index; host bit clear always taken
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= VRS_CTL_RST;
    end else if (wrDone && !idxPhase_q && regIdx_q == VRS_IDX_CTRL) begin
      ctrl_q <= shift_q & VRS_CTL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain sda: pull low for ack or a zero data bit
  always_ff @(posedge clk) begin
    if (rst) begin
      sdaOe <= 1'b0;
    end else if (startSeen || stopSeen) begin
      sdaOe <= 1'b0;
    end else if (state_q == VRS_ADDR && sclFall && bitCnt_q == 4'h8) begin
      sdaOe <= shift_q[7:1] == VRS_DEV_ADDR;
    end else if (wrDone) begin
      sdaOe <= idxPhase_q || regIdx_q != VRS_IDX_VOLT || shift_q[7] == ~(^shift_q[6:0]);
    end else if (state_q == VRS_ACK && sclFall) begin
      sdaOe <= ackOk_q && readMode_q && !rdData[7];
    end else if (state_q == VRS_TXB && sclFall) begin
      sdaOe <= bitCnt_q != 4'h7 && !shift_q[6];
    end else if (state_q == VRS_MACK && sclFall) begin
      sdaOe <= 1'b0;
    end
  end
  assign sdaOut = 1'b0;

  assign voltCode = volt_q[6:0];
  assign voltParity = volt_q[7];
  assign hostControl = ctrl_q[VRS_CTL_HOST];
  assign protSuppress = ctrl_q[VRS_CTL_SUPP];
  assign lightLoadPwm = ctrl_q[VRS_CTL_PWM];
  assign protLatchOff = ctrl_q[VRS_CTL_LATCH];

  ////////////////////////////////////////////////////////////////////////////
  sequence s_badVolt;
    wrDone && !idxPhase_q && regIdx_q == VRS_IDX_VOLT && shift_q[7] != ~(^shift_q[6:0]);
  endsequence
  a_parity_nack: assert property (@(posedge clk) disable iff (rst)
    s_badVolt |=> !sdaOe && $stable(volt_q)) else $error("bad parity acked");
  a_parity_store: assert property (@(posedge clk) disable iff (rst)
    wrDone && !idxPhase_q && regIdx_q == VRS_IDX_VOLT && shift_q[7] == ~(^shift_q[6:0])
    |=> volt_q == $past(shift_q) && sdaOe) else $error("good voltage not stored");
  a_volt_parity: assert property (@(posedge clk) disable iff (rst)
    volt_q[7] == ~(^volt_q[6:0])) else $error("stored parity wrong");
  a_host_clear: assert property (@(posedge clk) disable iff (rst)
    wrDone && !idxPhase_q && regIdx_q == VRS_IDX_CTRL && !shift_q[VRS_CTL_HOST]
    |=> !hostControl) else $error("host clear ignored");
  a_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
    !(wrDone && !idxPhase_q && regIdx_q == VRS_IDX_CTRL) |=> $stable(ctrl_q))
    else $error("control changed unbidden");
  a_addr_ack: assert property (@(posedge clk) disable iff (rst)
    state_q == VRS_ADDR && sclFall && bitCnt_q == 4'h8 && !startSeen && !stopSeen
    |=> sdaOe == (shift_q[7:1] == VRS_DEV_ADDR)) else $error("address ack wrong");
  a_skip_quiet: assert property (@(posedge clk) disable iff (rst)
    state_q == VRS_SKIP ##1 state_q == VRS_SKIP |-> !sdaOe)
    else $error("drives while skipping");
  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    stopSeen && !startSeen |=> state_q == VRS_IDLE) else $error("stop not idle");
  a_reset_vals: assert property (@(posedge clk)
    rst |=> volt_q[6:0] == VRS_VOLT_RST && !hostControl && !protSuppress &&
    lightLoadPwm && protLatchOff) else $error("reset values wrong");
endmodule
`default_nettype wire

// ==== test/vrs_bus_master.sv ====
// i2c bus controller model: drives scl and pulls sda low, bit period 48 ns
`default_nettype none
module vrs_bus_master (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idles high on both lines; scl stands still between frames
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic start();
    sdaLow = 1'b1;
    #24;
    scl = 1'b0;
  endtask
  task automatic stop();
    #12;
    sdaLow = 1'b1;
    #12;
    scl = 1'b1;
    #24;
    sdaLow = 1'b0;
    #48;
  endtask
  // data moves mid-low so the target never sees a false start or stop
  task automatic xfer(input logic b, output logic s);
    #12;
    sdaLow = ~b;
    #12;
    scl = 1'b1;
    #24;
    s = sda;
    scl = 1'b0;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], s);
    end
    xfer(1'b1, s);
    ack = ~s;
  endtask
  // nack after the byte: only one byte per read is served
  task automatic rdByte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, s);
      d[i] = s;
    end
    xfer(1'b1, s);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                    output logic ak, output logic ack);
    logic k;
    start();
    wrByte({a, 1'b0}, ak);
    wrByte(idx, k);
    wrByte(d, ack);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== test/vrs_i2c_slave_test.sv ====
// self-checking bench for the regulator i2c register slave
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
module vrs_i2c_slave_test
  import vrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclIn = 1'b1;
  logic sdaIn = 1'b1;
  logic scl, sdaLow, sdaOut, sdaOe, voltParity, hostControl, protSuppress;
  logic lightLoadPwm, protLatchOff, ak, ack, bad;
  logic [6:0] voltCode, code, prev;
  logic [7:0] d, c, cq;
  logic [31:0] xs = 32'hc1c44bdd;
  wire sdaWire = ~(sdaLow | sdaOe);
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  // pins reach the target through the bench clock edge
  always @(posedge clk) begin
    sclIn <= scl;
    sdaIn <= sdaWire;
  end
  vrs_bus_master m (.scl(scl), .sdaLow(sdaLow), .sda(sdaWire));
  vrs_i2c_slave u_dut (.clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .voltCode(voltCode), .voltParity(voltParity), .hostControl(hostControl),
    .protSuppress(protSuppress), .lightLoadPwm(lightLoadPwm), .protLatchOff(protLatchOff));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] ctl();
    return {hostControl, 2'b00, protSuppress, lightLoadPwm, 2'b00, protLatchOff};
  endfunction
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    logic k;
    m.start();
    m.wrByte({VRS_DEV_ADDR, 1'b0}, k);
    m.wrByte(idx, k);
    m.stop();
    m.start();
    m.wrByte({VRS_DEV_ADDR, 1'b1}, k);
    m.rdByte(q);
    m.stop();
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang is cut off well past the expected 15k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // half-step offset keeps every bus change off a rising clock edge
    #0.5;
    `CHK("voltCode", VRS_VOLT_RST, voltCode)
    `CHK("voltParity", ~^VRS_VOLT_RST, voltParity)
    `CHK("ctrl", VRS_CTL_RST, ctl())
    rd(VRS_IDX_VOLT, d);
    `CHK("readVolt", {~^VRS_VOLT_RST, VRS_VOLT_RST}, d)
    for (int i = 0; i < 8; i++) begin
      xs = nxt(xs);
      code = xs[6:0];
      bad = (i == 0) | xs[9];
      prev = voltCode;
      // parity from the code, flipped on purpose when bad
      m.wr(VRS_DEV_ADDR, VRS_IDX_VOLT, {~^code ^ bad, code}, ak, ack);
      `CHK("addrAck", 1'b1, ak)
      `CHK("dataAck", ~bad, ack)
      if (bad) begin
        `CHK("voltHeld", prev, voltCode)
        m.wr(VRS_DEV_ADDR, VRS_IDX_VOLT, {~^code, code}, ak, ack);
      end
      `CHK("voltCode", code, voltCode)
      `CHK("voltParity", ~^code, voltParity)
      rd(VRS_IDX_VOLT, d);
      `CHK("readVolt", {~^code, code}, d)
      c = (i == 1) ? 8'hff : xs[23:16];
      m.wr(VRS_DEV_ADDR, VRS_IDX_CTRL, c, ak, ack);
      `CHK("ctrl", c & VRS_CTL_MASK, ctl())
      rd(VRS_IDX_CTRL, d);
      `CHK("readCtrl", c & VRS_CTL_MASK, d)
      m.wr(VRS_DEV_ADDR, VRS_IDX_CTRL, c & 8'h7f, ak, ack);
      `CHK("hostOff", 1'b0, hostControl)
    end
    cq = ctl();
    prev = voltCode;
    m.wr(VRS_DEV_ADDR ^ 7'h01, VRS_IDX_VOLT, 8'h80, ak, ack);
    `CHK("foreignAck", 1'b0, ak)
    `CHK("foreignVolt", prev, voltCode)
    m.wr(VRS_DEV_ADDR, 8'h02, ~cq, ak, ack);
    `CHK("ctrlHeld", cq, ctl())
    `CHK("sdaOut", 1'b0, sdaOut)
    `CHK("sdaOe", 1'b0, sdaOe)
    end_sim();
  end
endmodule
`default_nettype wire
